// *** logic/scou_map.vh ***
`ifndef SCOU_MAP_VH
`define SCOU_MAP_VH
// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define SCOU_CMD_RUNTIME_WRITE 5'h17
`define SCOU_CMD_UNLOCK 5'h10
`define SCOU_CMD_SETTINGS_LOAD 5'h1F
`define SCOU_CMD_SETTINGS_BURN 5'h19
`define SCOU_CMD_SETTINGS_READ 5'h0F
`define SCOU_CMD_ANALOG_READ 5'h09
`define SCOU_UNLOCK_KEY 16'h8CAE
// ---------------------------------------------------------------
// frame shape
// ---------------------------------------------------------------
`define SCOU_CMD_BITS 5
`define SCOU_NORM_BITS 16
`define SCOU_EXT_BITS 46
`define SCOU_EXT_CLKS_PER_BIT 4
// ---------------------------------------------------------------
// runtime control word fields
// ---------------------------------------------------------------
`define SCOU_RT_SLEEP 15
`define SCOU_RT_GRESET 14
`define SCOU_RT_TESTBUS 9
`define SCOU_RT_OBSKIP 8
`define SCOU_RT_RESET 16'h0000
// ---------------------------------------------------------------
// settings word fields
// ---------------------------------------------------------------
`define SCOU_OTP_TEST_HI 45
`define SCOU_OTP_TEST_LO 44
`define SCOU_OTP_LOCK 13
`define SCOU_OTP_INVERT 11
`define SCOU_OTP_SINE_COMMON_MODE_SELECT 10
`define SCOU_OTP_COSINE_COMMON_MODE_SELECT 9
`define SCOU_OTP_GAIN_HI 8
`define SCOU_OTP_GAIN_LO 7
`define SCOU_OTP_BIAS 6
`define SCOU_OTP_HALL_HI 5
`define SCOU_OTP_HALL_LO 0
`define SCOU_OTP_USER_TOP 11
`define SCOU_OTP_RESET 46'h0000_0000_0000
`endif

// *** logic/scou_sync.v ***
`timescale 1ns/10ps
// ---------------------------------------------------------------
// two-flop synchroniser for one pin
// ---------------------------------------------------------------
module scou_sync (
  input wire clk,      // system clock
  input wire reset_n,  // async reset
  input wire pin_in,   // asynchronous input
  output wire pin_sync // synchronised level
);
  reg stage1;
  reg stage2;

  // first stage read only by the second
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
    end
  end

  assign pin_sync = stage2;
endmodule // scou_sync

// *** logic/scou_cmd_unit.v ***
`timescale 1ns/10ps
`include "scou_map.vh"
// Operation
// (R1) write 10111 loads control word; bit15 sleep, bit14 global reset
// (R2) control bit 9 routes sine/cosine after amplifier to test bus
// (R3) control bit 8 disables and bypasses output buffer
// (R4) host sends unlock command 16 in normal mode before extended access; here readback command 01001 also runs without the unlock
// (R5) host keeps reserved settings bits 12 and up unchanged
// (R6) settings bit 11 inverts sine and cosine before amplifier
// (R7) settings bit 10 puts common mode on negative sine pin
// (R8) settings bit 9 puts common mode on negative cosine pin
// (R9) settings bits 8:7 form the two-bit amplifier gain
// (R10) settings bit 6 selects 1.5V or 2.5V output bias
// (R11) settings bits 5:0 form the six-bit hall bias code
// (R12) settings bit 13 locks factory trim bits against change
// (R13) device holds a 46-bit programmable word, written over the link
// (R14) bits 44 and 45 reserved for cell test, carry no setting
// (R15) extended mode uses four serial clocks per data bit
// (R16) command 01001 presents one programmed cell per bit phase
// (R17) normal frame: C4..C0 then D15..D0, msb first
// (R18) upper command bits pick normal/extended read/write
// (R19) extended frame has 46 data bits, normal has 16
// (R20) access starts at chip select rise; low holds interface reset
// (R21) extended write 25 burns the supplied bits permanently
// (R22) 11111 loads settings unburnt; 01111 reads them back
// (R23) sample on rising clock edges; release data line at select fall
module scou_cmd_unit #(
  parameter NORM_BITS = `SCOU_NORM_BITS,
  parameter EXT_BITS = `SCOU_EXT_BITS
) (
  input wire clk,                         // 10 MHz system clock
  input wire reset_n,                     // async reset, active low
  input wire chip_select,                 // link select pin, high active
  input wire serial_link_clock,           // link clock pin from host
  input wire serial_bidir_line_in,        // data line as seen at pin
  output reg serial_bidir_line_out,       // data driven by device
  output reg serial_bidir_line_oe,        // high while device drives
  output reg burn_voltage_pin_readback,   // level of cell under readback
  output reg analog_readback_active,      // burn pin acts as output
  output reg burn_pulse,                  // one-cycle burn strobe
  output reg [EXT_BITS-1:0] burn_pattern, // bits to burn
  output reg low_power_request,           // sleep, outputs silenced
  output reg global_reset_pulse,          // one-cycle global reset
  output reg test_bus_route,              // channels onto test bus
  output reg output_buffer_skip,          // output buffer bypassed
  output reg invert_channels,             // sine/cosine inverted
  output reg sine_common_mode_select,     // neg sine pin carries cm
  output reg cosine_common_mode_select,   // neg cosine pin carries cm
  output reg [1:0] amp_gain,              // amplifier gain code
  output reg output_bias_level_select,    // 0 low bias, 1 high bias
  output reg [5:0] hall_bias,             // hall bias code
  output reg trim_locked                  // factory trim locked
);
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_CMD = 3'd1;
  localparam ST_DATA = 3'd2;
  localparam ST_DONE = 3'd3;
  localparam ST_WAIT = 3'd4;

  wire cs_s;
  wire sclk_s;
  wire din_s;
  reg sclk_d;
  reg [2:0] state;
  reg [2:0] cmd_cnt;
  reg [4:0] cmd;
  reg [5:0] bit_cnt;
  reg [1:0] phase;
  reg [EXT_BITS-1:0] shreg;
  reg unlocked;
  reg [15:0] runtime_control_word;
  reg [EXT_BITS-1:0] programmable_settings_word;
  reg [EXT_BITS-1:0] burned;
  reg [EXT_BITS-1:0] next_settings;

  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire is_ext = cmd[3];                    // see (R18)
  wire is_write = cmd[4];                  // see (R18)
  wire [5:0] frame_bits = is_ext ? EXT_BITS[5:0] : NORM_BITS[5:0]; // see (R19)
  wire last_phase = !is_ext || (phase == 2'd3); // see (R15)
  // one cycle per complete frame; cut frames never get here
  wire frame_done = (state == ST_DONE);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  scou_sync u_sync_cs (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in(chip_select),
    .pin_sync(cs_s)
  );
  scou_sync u_sync_clk (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in(serial_link_clock),
    .pin_sync(sclk_s)
  );
  scou_sync u_sync_din (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in(serial_bidir_line_in),
    .pin_sync(din_s)
  );

  // edge history of the synchronised link clock
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  // settings update: lock guards the trim field, test bits untouched
  always @* begin
    next_settings = programmable_settings_word;
    next_settings[`SCOU_OTP_USER_TOP:0] = shreg[`SCOU_OTP_USER_TOP:0];
    if (!programmable_settings_word[`SCOU_OTP_LOCK]) begin
      next_settings[`SCOU_OTP_TEST_LO-1:`SCOU_OTP_USER_TOP+1] =
        shreg[`SCOU_OTP_TEST_LO-1:`SCOU_OTP_USER_TOP+1]; // see (R12) (R5)
    end
  end

  // ---------------------------------------------------------------
  // link frame engine
  // ---------------------------------------------------------------
  // state, counters and shift register only; register updates and
  // pin drivers sit in processes of their own, one owner per signal
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      cmd_cnt <= 3'd0;
      cmd <= 5'h00;
      bit_cnt <= 6'd0;
      phase <= 2'd0;
      shreg <= `SCOU_OTP_RESET;
    end else if (!cs_s) begin
      // interface held in reset while select is low
      state <= ST_IDLE; // see (R20)
    end else begin
      case (state)
        ST_IDLE: begin
          // select rise opens a new frame
          state <= ST_CMD; // see (R20)
          cmd_cnt <= 3'd0;
          bit_cnt <= 6'd0;
          phase <= 2'd0;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            cmd <= {cmd[3:0], din_s}; // see (R17) (R23)
            cmd_cnt <= cmd_cnt + 3'd1;
            if (cmd_cnt == 3'd4) begin
              // preload, so read frames shift out the current word
              state <= ST_DATA;
              shreg <= programmable_settings_word;
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            phase <= is_ext ? phase + 2'd1 : 2'd0; // see (R15)
            if (last_phase) begin
              if (is_write) begin
                shreg <= {shreg[EXT_BITS-2:0], din_s}; // see (R17) (R23)
              end
              bit_cnt <= bit_cnt + 6'd1;
              if (bit_cnt == frame_bits - 6'd1) begin
                state <= ST_DONE;
              end
            end
          end
        end
        ST_DONE: begin
          // stays one cycle only, so every action fires once
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          // surplus link clocks are ignored until select falls
          state <= ST_WAIT;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // answer path: data line and burn pin readback
  // ---------------------------------------------------------------
  // answers move on the falling link edge, so the host sees a
  // settled level at its next rising edge
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_bidir_line_out <= 1'b0;
      serial_bidir_line_oe <= 1'b0;
      burn_voltage_pin_readback <= 1'b0;
      analog_readback_active <= 1'b0;
    end else if (!cs_s) begin
      // select low: both pins let go together
      serial_bidir_line_oe <= 1'b0; // see (R23)
      analog_readback_active <= 1'b0;
    end else begin
      if (state == ST_CMD && sclk_rise && cmd_cnt == 3'd4 &&
          {cmd[3:0], din_s} == `SCOU_CMD_ANALOG_READ) begin
        // burn pin turns into a readback output
        analog_readback_active <= 1'b1; // see (R16)
      end
      if (state == ST_DATA && sclk_fall && !is_write) begin
        if (cmd == `SCOU_CMD_SETTINGS_READ && unlocked) begin
          serial_bidir_line_oe <= 1'b1; // see (R22)
          serial_bidir_line_out <= shreg[EXT_BITS-1 - bit_cnt];
        end
        if (analog_readback_active) begin
          burn_voltage_pin_readback <= burned[EXT_BITS-1 - bit_cnt]; // see (R16)
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // runtime control word
  // ---------------------------------------------------------------
  // global reset is a strobe, the rest of the word is a level
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      runtime_control_word <= `SCOU_RT_RESET;
      global_reset_pulse <= 1'b0;
    end else begin
      global_reset_pulse <= 1'b0;
      if (frame_done && cmd == `SCOU_CMD_RUNTIME_WRITE) begin
        runtime_control_word <= shreg[15:0]; // see (R1)
        global_reset_pulse <= shreg[`SCOU_RT_GRESET]; // see (R1)
      end
    end
  end

  // ---------------------------------------------------------------
  // extended access unlock
  // ---------------------------------------------------------------
  // survives select low on purpose; a wrong key locks again
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unlocked <= 1'b0;
    end else begin
      if (frame_done && cmd == `SCOU_CMD_UNLOCK) begin
        unlocked <= (shreg[15:0] == `SCOU_UNLOCK_KEY); // see (R4)
      end
    end
  end

  // ---------------------------------------------------------------
  // settings word and burn strobe
  // ---------------------------------------------------------------
  // burned copy stands in for the fuse cells; the strobe and the
  // pattern are what the programming circuit would act on
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      programmable_settings_word <= `SCOU_OTP_RESET;
      burned <= `SCOU_OTP_RESET;
      burn_pattern <= `SCOU_OTP_RESET;
      burn_pulse <= 1'b0;
    end else begin
      burn_pulse <= 1'b0;
      if (frame_done && unlocked) begin
        if (cmd == `SCOU_CMD_SETTINGS_LOAD) begin
          programmable_settings_word <= next_settings; // see (R22) (R13)
        end
        if (cmd == `SCOU_CMD_SETTINGS_BURN) begin
          // cells only ever go from 0 to 1
          burned <= burned | next_settings; // see (R21) (R13)
          programmable_settings_word <= burned | next_settings;
          burn_pattern <= next_settings; // see (R21)
          burn_pulse <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // decoded controls, registered
  // ---------------------------------------------------------------
  // runtime controls, one cycle behind the word
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_power_request <= 1'b0;
      test_bus_route <= 1'b0;
      output_buffer_skip <= 1'b0;
    end else begin
      low_power_request <= runtime_control_word[`SCOU_RT_SLEEP]; // see (R1)
      test_bus_route <= runtime_control_word[`SCOU_RT_TESTBUS]; // see (R2)
      output_buffer_skip <= runtime_control_word[`SCOU_RT_OBSKIP]; // see (R3)
    end
  end

  // settings controls, registered so the analog side sees clean levels
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      invert_channels <= 1'b0;
      sine_common_mode_select <= 1'b0;
      cosine_common_mode_select <= 1'b0;
      amp_gain <= 2'd0;
      output_bias_level_select <= 1'b0;
      hall_bias <= 6'd0;
      trim_locked <= 1'b0;
    end else begin
      invert_channels <= programmable_settings_word[`SCOU_OTP_INVERT]; // see (R6)
      sine_common_mode_select <= programmable_settings_word[`SCOU_OTP_SINE_COMMON_MODE_SELECT]; // see (R7)
      cosine_common_mode_select <= programmable_settings_word[`SCOU_OTP_COSINE_COMMON_MODE_SELECT]; // see (R8)
      amp_gain <= programmable_settings_word[`SCOU_OTP_GAIN_HI:`SCOU_OTP_GAIN_LO]; // see (R9)
      output_bias_level_select <= programmable_settings_word[`SCOU_OTP_BIAS]; // see (R10)
      hall_bias <= programmable_settings_word[`SCOU_OTP_HALL_HI:`SCOU_OTP_HALL_LO]; // see (R11)
      trim_locked <= programmable_settings_word[`SCOU_OTP_LOCK]; // see (R12)
    end
  end

  // bits 45:44 are never decoded into any setting, see (R14)
  // limitation: they are only ever carried through load and burn,
  // so a host that writes them sees its value ignored
endmodule // scou_cmd_unit

// *** verification/scou_cmd_unit_sva.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// link unit checker
// ----------------------------------------
module scou_cmd_unit_sva #(
  parameter EXT_BITS = 46
) (
  input logic clk, // system clock
  input logic reset_n, // async reset
  input logic chip_select, // link select
  input logic serial_link_clock, // link clock
  input logic serial_bidir_line_out, // device data
  input logic serial_bidir_line_oe, // device drives
  input logic analog_readback_active, // readback phase
  input logic burn_pulse, // burn strobe
  input logic [EXT_BITS-1:0] burn_pattern, // burned bits
  input logic global_reset_pulse, // reset strobe
  input logic [5:0] hall_bias, // hall code
  input logic [1:0] amp_gain, // gain code
  input logic trim_locked // lock bit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // select seen low long enough to pass the synchroniser
  sequence s_idle_sel;
    !chip_select [*4];
  endsequence
  property p_oe_idle; s_idle_sel |-> !serial_bidir_line_oe; endproperty
  property p_ana_idle; s_idle_sel |-> !analog_readback_active; endproperty
  property p_burn_once; burn_pulse |=> !burn_pulse; endproperty
  property p_grst_once; global_reset_pulse |=> !global_reset_pulse; endproperty
  property p_burn_pat; $changed(burn_pattern) |-> burn_pulse; endproperty
  property p_lock_hold; trim_locked |=> trim_locked; endproperty
  property p_set_frame; ($changed(hall_bias) || $changed(amp_gain)) |-> chip_select; endproperty
  // read bits move only after a falling link clock
  property p_bit_fall;
    ($changed(serial_bidir_line_out) && serial_bidir_line_oe) |-> !$past(serial_link_clock, 2);
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data line driven while idle");
  a_ana_idle: assert property (p_ana_idle) else $error("readback while idle");
  a_burn_once: assert property (p_burn_once) else $error("burn strobe too long");
  a_grst_once: assert property (p_grst_once) else $error("reset strobe too long");
  a_burn_pat: assert property (p_burn_pat) else $error("pattern moved without burn");
  a_lock_hold: assert property (p_lock_hold) else $error("lock cleared");
  a_set_frame: assert property (p_set_frame) else $error("settings moved outside frame");
  a_bit_fall: assert property (p_bit_fall) else $error("read bit moved early");
endmodule // scou_cmd_unit_sva
bind scou_cmd_unit scou_cmd_unit_sva #(.EXT_BITS(EXT_BITS)) u_scou_cmd_unit_sva (
  .clk(clk), .reset_n(reset_n), .chip_select(chip_select),
  .serial_link_clock(serial_link_clock), .serial_bidir_line_out(serial_bidir_line_out),
  .serial_bidir_line_oe(serial_bidir_line_oe), .analog_readback_active(analog_readback_active),
  .burn_pulse(burn_pulse), .burn_pattern(burn_pattern), .global_reset_pulse(global_reset_pulse),
  .hall_bias(hall_bias), .amp_gain(amp_gain), .trim_locked(trim_locked));

// *** verification/scou_host_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// host side of the three-wire link
// ----------------------------------------
module scou_host_model (
  input logic clk, // system clock
  input logic line, // resolved data line
  input logic readback, // burn pin level
  output logic chip_select, // link select
  output logic serial_link_clock, // link clock, idle low
  output logic host_bit, // host data
  output logic host_oe // host drives line
);
  logic smp;
  logic smp_ana;
  initial begin
    chip_select = 0;
    serial_link_clock = 0;
    host_bit = 0;
    host_oe = 0;
  end
  // one 800 ns link clock, sampled just before it rises
  task automatic pulse;
    repeat (4) @(posedge clk);
    smp = line;
    smp_ana = readback;
    serial_link_clock <= 1;
    repeat (4) @(posedge clk);
    serial_link_clock <= 0;
  endtask
  // whole frame; reads capture the level once per bit, in its last phase
  task automatic frame(input logic [4:0] cmd, input logic [45:0] d, input int nb,
                       output logic [45:0] rd);
    int cpb;
    cpb = cmd[3] ? 4 : 1;
    rd = 0;
    @(posedge clk);
    chip_select <= 1;
    host_oe <= 1;
    for (int i = 4; i >= 0; i--) begin
      host_bit <= cmd[i];
      pulse();
    end
    host_oe <= cmd[4]; // released for reads, pull-up takes over
    for (int i = nb - 1; i >= 0; i--) begin
      host_bit <= d[i];
      for (int k = 0; k < cpb; k++) pulse();
      rd = {rd[44:0], (cmd == 5'h09) ? smp_ana : smp};
    end
    repeat (4) @(posedge clk);
    chip_select <= 0;
    host_oe <= 0;
    repeat (8) @(posedge clk);
  endtask
endmodule // scou_host_model

// *** verification/tb.sv ***
`timescale 1ns/10ps
`include "scou_map.vh"
module tb;
  logic clk, reset_n, cs, sclk, hbit, hoe, line, oe, dout, rb, ana, bp, lpr, grp, tbr, obs;
  logic inv, cms, cmc, bias, lock;
  logic [45:0] pat, rd;
  logic [1:0] gain;
  logic [5:0] hall;
  int bad_count, compares, grst_seen, burn_seen;
  // pull-up wins when nobody drives
  assign line = oe ? dout : (hoe ? hbit : 1'b1);
  scou_cmd_unit u_scou_cmd_unit (.clk(clk), .reset_n(reset_n), .chip_select(cs),
    .serial_link_clock(sclk), .serial_bidir_line_in(line), .serial_bidir_line_out(dout),
    .serial_bidir_line_oe(oe), .burn_voltage_pin_readback(rb), .analog_readback_active(ana),
    .burn_pulse(bp), .burn_pattern(pat), .low_power_request(lpr), .global_reset_pulse(grp),
    .test_bus_route(tbr), .output_buffer_skip(obs), .invert_channels(inv),
    .sine_common_mode_select(cms), .cosine_common_mode_select(cmc), .amp_gain(gain),
    .output_bias_level_select(bias), .hall_bias(hall), .trim_locked(lock));
  scou_host_model u_scou_host_model (.clk(clk), .line(line), .readback(rb), .chip_select(cs),
    .serial_link_clock(sclk), .host_bit(hbit), .host_oe(hoe));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // count strobes, they stand one cycle only
  always @(posedge clk) begin
    grst_seen += (grp === 1'b1);
    burn_seen += (bp === 1'b1);
  end
  task chk(input string n, input logic [45:0] e, input logic [45:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task xfer(input logic [4:0] c, input logic [45:0] d, input int nb);
    u_scou_host_model.frame(c, d, nb, rd);
  endtask
  task results;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard
  initial begin
    #5000000;
    bad_count++;
    results();
  end
  initial begin
    reset_n = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1;
    repeat (3) @(posedge clk);
    xfer(`SCOU_CMD_RUNTIME_WRITE, 16'h8300, 16);
    chk("sleep", 1'h1, lpr);
    chk("testbus", 1'h1, tbr);
    chk("obskip", 1'h1, obs);
    xfer(`SCOU_CMD_RUNTIME_WRITE, 16'h4000, 16);
    chk("sleep", 1'h0, lpr);
    chk("greset", 1'h1, grst_seen == 1);
    $display("runtime test done");
    xfer(`SCOU_CMD_SETTINGS_LOAD, 12'hAC5, 46);
    chk("locked hall", 6'h00, hall);
    xfer(`SCOU_CMD_RUNTIME_WRITE, 8'hFF, 8);
    chk("short frame", 1'h0, lpr);
    $display("refusal test done");
    xfer(`SCOU_CMD_UNLOCK, `SCOU_UNLOCK_KEY, 16);
    xfer(`SCOU_CMD_SETTINGS_LOAD, 12'hAC5, 46);
    chk("invert", 1'h1, inv);
    chk("sine_common_mode_select", 1'h0, cms);
    chk("cosine_common_mode_select", 1'h1, cmc);
    chk("gain", 2'h1, gain);
    chk("bias", 1'h1, bias);
    chk("hall", 6'h05, hall);
    xfer(`SCOU_CMD_SETTINGS_READ, 1'h0, 46);
    chk("read", 12'hAC5, rd);
    $display("settings test done");
    xfer(`SCOU_CMD_SETTINGS_BURN, 16'h2003, 46);
    chk("burns", 1'h1, burn_seen == 1);
    chk("pattern", 16'h2003, pat);
    chk("lock", 1'h1, lock);
    xfer(`SCOU_CMD_SETTINGS_LOAD, 46'h0010_0000_2011, 46);
    xfer(`SCOU_CMD_SETTINGS_READ, 1'h0, 46);
    chk("trim kept", 16'h2011, rd);
    xfer(`SCOU_CMD_ANALOG_READ, 1'h0, 46);
    chk("analog", 16'h2003, rd);
    $display("burn test done");
    results();
  end
endmodule // tb
